// ### sirq_pkg.sv
// Package of constants and types for the serial interrupt reporter
// Summary of operation
// - Shared open-drain line, drive only permitted slots
// - Cycle is start, data frames, then stop
// - Quiet mode: device drives one low clock
// - Continuous mode: only host starts a cycle
// - After reset assume continuous, await host start
// - Count frames from rising edge ending start
// - Data frame is sample, recovery, turnaround
// - Sample clock: drive low if request active
// - Recovery drives high; turnaround stays released
// - Frame n carries request n-1 map
// - Slots aligned to clock edges from frame one
// - Stop length two quiet, three continuous
// - Accept idle or immediate next start
// - Quiet start only when a request pending
package sirq_pkg;
   localparam int SIRQ_NSRC = 32;
   localparam int SIRQ_NFRAMES = 32;
   localparam logic [3:0] SIRQ_START_MIN = 4'h4;
   localparam logic [3:0] SIRQ_START_MAX = 4'h8;
   localparam logic [3:0] SIRQ_STOP_QUIET = 4'h2;
   localparam logic [3:0] SIRQ_STOP_CONT = 4'h3;
   localparam logic [1:0] SIRQ_PH_SAMPLE = 2'h0;
   localparam logic [1:0] SIRQ_PH_RECOV = 2'h1;
   localparam logic [1:0] SIRQ_PH_TURN = 2'h2;

   typedef enum logic [2:0] {
      SIRQ_IDLE = 3'b000,
      SIRQ_QSTART = 3'b001,
      SIRQ_START = 3'b010,
      SIRQ_FRAMES = 3'b011,
      SIRQ_STOP = 3'b100
   } sirq_state_t;

   typedef struct packed {
      logic in;
      logic out;
      logic oe;
   } sirq_pin_t;
endpackage : sirq_pkg

// ### sirq_latch.sv
// Pending latch for one interrupt source
`timescale 1ns/1ps
module sirq_latch
   import sirq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Source and clear
   input wire logic req,
   input wire logic clr,
   output logic pend
);
   typedef struct packed {
      logic pend;
   } sirq_lst_t;
   sirq_lst_t st_r;
   sirq_lst_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      // Set wins over clear
      st_nxt.pend = req | (st_r.pend & ~clr);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         st_r <= '0;
      else if (ce)
         st_r <= st_nxt;
   end

   assign pend = st_r.pend | req;

   latch_hold_a: assert property (@(posedge clk) disable iff (reset)
      ce && req |=> st_r.pend)
      else $error("request not latched");
   latch_clear_a: assert property (@(posedge clk) disable iff (reset)
      ce && clr && !req |=> !st_r.pend)
      else $error("reported request not cleared");
endmodule : sirq_latch

// ### sirq_frame_cnt.sv
// Frame and phase counter
`timescale 1ns/1ps
module sirq_frame_cnt
   import sirq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Control
   input wire logic clear,
   input wire logic run,
   output logic [1:0] phase,
   output logic [5:0] frame
);
   typedef struct packed {
      logic [1:0] phase;
      logic [5:0] frame;
   } sirq_cnt_t;
   sirq_cnt_t st_r;
   sirq_cnt_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (clear)
      begin
         st_nxt = '0;
      end
      else if (run)
      begin
         if (st_r.phase == SIRQ_PH_TURN)
         begin
            st_nxt.phase = SIRQ_PH_SAMPLE;
            st_nxt.frame = st_r.frame + 6'h01;
         end
         else
         begin
            st_nxt.phase = st_r.phase + 2'h1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         st_r <= '0;
      else if (ce)
         st_r <= st_nxt;
   end

   assign phase = st_r.phase;
   assign frame = st_r.frame;

   phase_range_a: assert property (@(posedge clk) disable iff (reset)
      st_r.phase != 2'h3)
      else $error("phase out of range");
   phase_step_a: assert property (@(posedge clk) disable iff (reset)
      ce && run && !clear && st_r.phase == SIRQ_PH_SAMPLE |=> st_r.phase == SIRQ_PH_RECOV)
      else $error("sample not followed by recovery");
   clear_zero_a: assert property (@(posedge clk) disable iff (reset)
      ce && clear |=> st_r.phase == SIRQ_PH_SAMPLE && st_r.frame == 6'h00)
      else $error("counter not cleared at start");
   turn_wrap_a: assert property (@(posedge clk) disable iff (reset)
      ce && run && !clear && st_r.phase == SIRQ_PH_TURN
      |=> st_r.phase == SIRQ_PH_SAMPLE && st_r.frame == $past(st_r.frame) + 6'h01)
      else $error("turnaround not followed by next frame");
endmodule : sirq_frame_cnt

// ### sirq_slave.sv
// Serial interrupt reporter, device side
`timescale 1ns/1ps
module sirq_slave
   import sirq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Interrupt sources, index equals frame counter value
   input wire logic [SIRQ_NSRC-1:0] irq_src,
   // Shared line
   input wire logic line_in,
   output logic line_out,
   output logic line_oe,
   // Status
   output logic quiet_mode,
   output logic cycle_active
);
   typedef struct packed {
      sirq_state_t state;
      logic quiet;
      logic [3:0] lowcnt;
      logic drv;
      logic drv_hi;
      logic pulled;
      logic line_d;
   } sirq_st_t;
   sirq_st_t st_r;
   sirq_st_t st_nxt;

   logic [SIRQ_NSRC-1:0] pend;
   logic [SIRQ_NSRC-1:0] clr;
   logic [1:0] phase;
   logic [5:0] frame;
   logic cnt_clear;
   logic cnt_run;
   logic any_pend;
   logic rise;
   logic slot_pend;

   // ********************************
   // Pending latches
   // ********************************
   genvar gi;
   generate
      for (gi = 0; gi < SIRQ_NSRC; gi++)
      begin : g_src
         sirq_latch u_latch (
            .clk(clk),
            .reset(reset),
            .ce(ce),
            .req(irq_src[gi]),
            .clr(clr[gi]),
            .pend(pend[gi])
         );
         // Cleared once reported in its sample slot
         assign clr[gi] = (st_r.state == SIRQ_FRAMES) && (phase == SIRQ_PH_SAMPLE)
                          && (frame == 6'(gi)) && ce;
      end
   endgenerate

   // ********************************
   // Frame counter
   // ********************************
   sirq_frame_cnt u_cnt (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .clear(cnt_clear),
      .run(cnt_run),
      .phase(phase),
      .frame(frame)
   );

   assign any_pend = |pend;
   assign rise = line_in & ~st_r.line_d;
   assign slot_pend = pend[0];

   // ********************************
   // Cycle sequencer
   // ********************************
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.line_d = line_in;
      st_nxt.drv = 1'b0;
      st_nxt.drv_hi = 1'b0;
      cnt_clear = 1'b0;
      cnt_run = 1'b0;
      case (st_r.state)
         SIRQ_IDLE:
         begin
            if (!line_in)
            begin
               st_nxt.state = SIRQ_START;
               st_nxt.lowcnt = 4'h1;
            end
            else if (st_r.quiet && any_pend)
            begin
               st_nxt.state = SIRQ_QSTART;
               st_nxt.drv = 1'b1;
               st_nxt.lowcnt = 4'h0;
            end
         end
         SIRQ_QSTART:
         begin
            // Own low clock on the line now; release next
            st_nxt.state = SIRQ_START;
            st_nxt.lowcnt = 4'h1;
         end
         SIRQ_START:
         begin
            if (!line_in)
            begin
               if (st_r.lowcnt != 4'hf)
                  st_nxt.lowcnt = st_r.lowcnt + 4'h1;
            end
            else if (st_r.lowcnt >= SIRQ_START_MIN && st_r.lowcnt <= SIRQ_START_MAX)
            begin
               // Rising edge ends start; host high clock is here
               st_nxt.state = SIRQ_FRAMES;
               cnt_clear = 1'b1;
               st_nxt.drv = slot_pend;
               st_nxt.pulled = 1'b0;
            end
            else
            begin
               st_nxt.state = SIRQ_IDLE;
            end
         end
         SIRQ_FRAMES:
         begin
            cnt_run = 1'b1;
            if (phase == SIRQ_PH_SAMPLE)
            begin
               st_nxt.pulled = st_r.drv;
               st_nxt.drv = 1'b0;
               st_nxt.drv_hi = st_r.drv;
            end
            else if (phase == SIRQ_PH_TURN)
            begin
               if (!line_in && st_r.line_d && frame >= 6'(SIRQ_NFRAMES - 1))
               begin
                  st_nxt.state = SIRQ_STOP;
                  st_nxt.lowcnt = 4'h1;
               end
            end
            // Host stop may come earlier than all frames
            if (!line_in && !st_r.drv && !st_r.drv_hi && phase == SIRQ_PH_RECOV)
            begin
               // Recovery clock low with no device drive; sample clock counted as low too
               st_nxt.state = SIRQ_STOP;
               st_nxt.lowcnt = 4'h2;
               st_nxt.drv_hi = 1'b0;
            end
         end
         SIRQ_STOP:
         begin
            if (!line_in)
            begin
               if (st_r.lowcnt != 4'hf)
                  st_nxt.lowcnt = st_r.lowcnt + 4'h1;
            end
            else
            begin
               if (st_r.lowcnt == SIRQ_STOP_QUIET)
                  st_nxt.quiet = 1'b1;
               else if (st_r.lowcnt == SIRQ_STOP_CONT)
                  st_nxt.quiet = 1'b0;
               st_nxt.state = SIRQ_IDLE;
            end
         end
         default:
         begin
            st_nxt.state = SIRQ_IDLE;
         end
      endcase
      // Next sample slot drive, set one clock ahead
      if (st_r.state == SIRQ_FRAMES && phase == SIRQ_PH_TURN && st_nxt.state == SIRQ_FRAMES)
      begin
         st_nxt.drv = (frame + 6'h01 < 6'(SIRQ_NFRAMES)) ? pend[5'(frame + 6'h01)] : 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_r <= '0;
         st_r.state <= SIRQ_IDLE;
         st_r.line_d <= 1'b1;
      end
      else if (ce)
         st_r <= st_nxt;
   end

   // ********************************
   // Pin drive
   // ********************************
   assign line_oe = st_r.drv | st_r.drv_hi;
   assign line_out = st_r.drv_hi;
   assign quiet_mode = st_r.quiet;
   assign cycle_active = (st_r.state != SIRQ_IDLE);

   only_drive_a: assert property (@(posedge clk) disable iff (reset)
      line_oe |-> (st_r.state == SIRQ_QSTART || st_r.state == SIRQ_FRAMES))
      else $error("line driven outside slot");
   cont_nostart_a: assert property (@(posedge clk) disable iff (reset)
      st_r.state == SIRQ_IDLE && !st_r.quiet && ce |=> st_r.state != SIRQ_QSTART)
      else $error("device started in continuous mode");
   reset_cont_a: assert property (@(posedge clk)
      reset |=> !st_r.quiet && st_r.state == SIRQ_IDLE)
      else $error("reset mode not continuous");
   quiet_one_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_QSTART |-> line_oe && !line_out)
      else $error("quiet start low missing");
   quiet_need_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_IDLE && $past(st_r.state) != SIRQ_QSTART
      ##1 st_r.state == SIRQ_QSTART |-> $past(any_pend) && $past(st_r.quiet))
      else $error("quiet start without request");
   recov_high_a: assert property (@(posedge clk) disable iff (reset)
      st_r.state == SIRQ_FRAMES && phase == SIRQ_PH_SAMPLE && line_oe && ce
      && st_nxt.state == SIRQ_FRAMES |=> line_oe && line_out)
      else $error("recovery not driven high");
   turn_free_a: assert property (@(posedge clk) disable iff (reset)
      st_r.state == SIRQ_FRAMES && phase == SIRQ_PH_TURN |-> !line_oe || !line_out)
      else $error("turnaround driven high");
   stop_quiet_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_STOP && line_in && st_r.lowcnt == SIRQ_STOP_QUIET |=> quiet_mode)
      else $error("two clock stop missed quiet");
   stop_cont_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_STOP && line_in && st_r.lowcnt == SIRQ_STOP_CONT |=> !quiet_mode)
      else $error("three clock stop missed continuous");

   // ********************************
   // Frame sequencing checks
   // ********************************
   start_count_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_START && !line_in && st_r.lowcnt != 4'hf
      |=> st_r.lowcnt == $past(st_r.lowcnt) + 4'h1)
      else $error("start length not counted");

   start_short_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_START && line_in && st_r.lowcnt < SIRQ_START_MIN
      |=> st_r.state == SIRQ_IDLE)
      else $error("short start not refused");

   start_long_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_START && line_in && st_r.lowcnt > SIRQ_START_MAX
      |=> st_r.state == SIRQ_IDLE)
      else $error("long start not refused");

   start_end_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_START && line_in && st_r.lowcnt >= SIRQ_START_MIN
      && st_r.lowcnt <= SIRQ_START_MAX
      |=> st_r.state == SIRQ_FRAMES && phase == SIRQ_PH_SAMPLE && frame == 6'h00)
      else $error("frame count not started at start edge");

   first_slot_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_START && line_in && st_r.lowcnt >= SIRQ_START_MIN
      && st_r.lowcnt <= SIRQ_START_MAX |=> line_oe == $past(pend[0]))
      else $error("first frame drive wrong");

   sample_low_a: assert property (@(posedge clk) disable iff (reset)
      st_r.state == SIRQ_FRAMES && phase == SIRQ_PH_SAMPLE && line_oe |-> !line_out)
      else $error("sample slot not driven low");

   low_slot_a: assert property (@(posedge clk) disable iff (reset)
      line_oe && !line_out
      |-> st_r.state == SIRQ_QSTART || (st_r.state == SIRQ_FRAMES && phase == SIRQ_PH_SAMPLE))
      else $error("line pulled low outside a slot");

   high_slot_a: assert property (@(posedge clk) disable iff (reset)
      line_oe && line_out |-> st_r.state == SIRQ_FRAMES && phase == SIRQ_PH_RECOV)
      else $error("line driven high outside recovery");

   qstart_once_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_QSTART |=> !line_oe && st_r.state == SIRQ_START)
      else $error("quiet start low longer than one clock");

   quiet_go_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_IDLE && line_in && st_r.quiet && any_pend
      |=> st_r.state == SIRQ_QSTART)
      else $error("pending request did not start quiet cycle");

   idle_start_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_IDLE && !line_in
      |=> st_r.state == SIRQ_START && st_r.lowcnt == 4'h1)
      else $error("host start not taken");

   stop_enter_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_FRAMES && phase == SIRQ_PH_RECOV && !line_in
      && !st_r.drv && !st_r.drv_hi |=> st_r.state == SIRQ_STOP && st_r.lowcnt == 4'h2)
      else $error("stop frame not detected");

   stop_done_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_STOP && line_in |=> st_r.state == SIRQ_IDLE)
      else $error("cycle not ended after stop");

   stop_other_a: assert property (@(posedge clk) disable iff (reset)
      ce && st_r.state == SIRQ_STOP && line_in && st_r.lowcnt != SIRQ_STOP_QUIET
      && st_r.lowcnt != SIRQ_STOP_CONT |=> quiet_mode == $past(quiet_mode))
      else $error("odd stop length changed mode");
endmodule : sirq_slave

// ### sirq_host.sv
// Host controller model for the shared interrupt line
`timescale 1ns/1ps
module sirq_host
   import sirq_pkg::*;
(
   // Clock and wire
   input wire logic clk,
   input wire logic line_in,
   // Host drive
   output logic host_out,
   output logic host_oe
);
   logic line_s;
   logic [31:0] seen;
   int ok;

   initial
   begin
      host_out = 1'b1;
      host_oe = 1'b0;
   end

   always @(posedge clk)
      line_s <= line_in;

   task tick;
      @(posedge clk);
      #1;
   endtask : tick

   // Low for n clocks, high one clock, then released
   task pulse(input int n);
      host_out = 1'b0;
      host_oe = 1'b1;
      repeat (n) tick();
      host_out = 1'b1;
      tick();
      host_oe = 1'b0;
   endtask : pulse

   // One cycle: start, 32 sampled frames, stop
   task cycle(input int slen, input int plen, input bit quiet);
      int n;
      seen = '0;
      ok = 1;
      n = 0;
      // Idle clock keeps drive changes off the previous release
      tick();
      if (quiet)
      begin
         while (line_s !== 1'b0 && n < 50)
         begin
            tick();
            n++;
         end
         ok = (n < 50);
         pulse(slen - 1);
      end
      else
         pulse(slen);
      for (int k = 0; k < 32; k++)
      begin
         tick();
         seen[k] = ~line_s;
         repeat (2) tick();
      end
      pulse(plen);
   endtask : cycle
endmodule : sirq_host

// ### serial_irq_slave_test.sv
// Self-checking bench for the serial interrupt reporter
`timescale 1ns/1ps
module serial_irq_slave_test
   import sirq_pkg::*;
;
   logic clk;
   logic reset;
   logic ce;
   logic [SIRQ_NSRC-1:0] irq_src;
   logic line_out;
   logic line_oe;
   logic quiet_mode;
   logic cycle_active;
   logic host_out;
   logic host_oe;
   wire line;
   int fails;
   int cmp_count;
   int seed;
   int dev_cnt;
   logic [31:0] v;
   logic [31:0] pend_m;
   logic [31:0] exp_v;

   // ****************************************
   // Wire and instances
   // ****************************************
   assign line = !((line_oe && !line_out) || (host_oe && !host_out));

   sirq_slave i_dut (.clk(clk), .reset(reset), .ce(ce), .irq_src(irq_src), .line_in(line),
      .line_out(line_out), .line_oe(line_oe), .quiet_mode(quiet_mode),
      .cycle_active(cycle_active));
   sirq_host i_host (.clk(clk), .line_in(line), .host_out(host_out), .host_oe(host_oe));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Clocks in which the device drives
   always @(posedge clk)
      if (line_oe === 1'b1)
         dev_cnt <= dev_cnt + 1;

   task tick;
      @(posedge clk);
      #1;
   endtask : tick

   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task stop_test;
      $display("checks %0d errors %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      seed = 81367;
      fails = 0;
      cmp_count = 0;
      dev_cnt = 0;
      reset = 1'b1;
      ce = 1'b1;
      irq_src = 32'h0000_0000;
      repeat (6) @(posedge clk);
      #1 reset = 1'b0;
      irq_src = 32'h0000_0002;
      repeat (12) tick();
      check({30'h0, quiet_mode, cycle_active}, 32'h0000_0000);
      check(dev_cnt, 32'h0000_0000);
      pend_m = 32'h0000_0002;
      for (int i = 3; i <= 9; i++)
      begin
         v = $random(seed);
         irq_src = v;
         dev_cnt = 0;
         exp_v = (i >= 4 && i <= 8) ? (pend_m | v) : 32'h0000_0000;
         pend_m = (i >= 4 && i <= 8) ? v : (pend_m | v);
         i_host.cycle(i, 3, 1'b0);
         check(i_host.seen, exp_v);
         check(dev_cnt, 2 * $countones(exp_v));
      end
      irq_src = 32'h0000_0000;
      i_host.cycle(5, 2, 1'b0);
      check(i_host.seen, pend_m);
      repeat (2) tick();
      check({30'h0, quiet_mode, cycle_active}, 32'h0000_0002);
      dev_cnt = 0;
      repeat (12) tick();
      check(dev_cnt, 32'h0000_0000);
      ce = 1'b0;
      irq_src = 32'h0000_0002;
      repeat (3) tick();
      check({30'h0, quiet_mode, cycle_active}, 32'h0000_0002);
      check(dev_cnt, 32'h0000_0000);
      ce = 1'b1;
      tick();
      irq_src = 32'h0000_0000;
      i_host.cycle(6, 3, 1'b1);
      check(i_host.ok, 1);
      check(i_host.seen, 32'h0000_0002);
      check(dev_cnt, 3);
      repeat (2) tick();
      check({30'h0, quiet_mode, cycle_active}, 32'h0000_0000);
      stop_test();
   end
endmodule : serial_irq_slave_test
